// >>> hdl/ecab_unit.sv
// External-control word transfers and I/O ordering barrier for the load/store side
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module ecab_unit #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Op port from the pipeline
  input wire logic op_valid_i,
  input wire ecab_pkg::ecab_op_t op_i,
  input wire ecab_pkg::ecab_gpr_t gpr_i,
  output logic op_ready_o,
  // Result write-back
  output logic gpr_wr_valid_o,
  output logic [4:0] gpr_wr_tgt_o,
  output logic [63:0] gpr_wr_data_o,
  // Fault pulses
  output logic dsi_o,
  output logic align_o,
  output logic ill_o,
  // Address translation handshake
  output logic xl_req_o,
  output logic [63:0] xl_ea_o,
  output logic xl_store_o,
  input wire logic xl_ack_i,
  input wire logic [63:0] xl_paddr_i,
  input wire logic xl_fault_i,
  // Memory queue
  output logic mem_valid_o,
  output ecab_pkg::ecab_mreq_t mem_req_o,
  input wire logic mem_ready_i,
  input wire logic mem_ack_i,
  input wire ecab_pkg::ecab_mack_t mem_ack_data_i,
  // Barrier broadcast
  output logic bcast_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // Sequencer state
  ecab_pkg::ecab_state_t state;
  // Staged request waiting for the ordering check
  ecab_pkg::ecab_mreq_t hold_q;
  // Latched instruction context
  logic [4:0] tgt_q;
  logic st_q;
  logic [31:0] src_q;
  logic [ecab_pkg::RID_W-1:0] rid_q;
  // Outstanding counts and barrier fences per class
  logic [CNT_W-1:0] cnt1;
  logic [CNT_W-1:0] cnt2;
  logic fence1;
  logic fence2;
  // Software registers
  logic [31:0] ext_access_reg;
  logic [31:0] ctrl_reg;
  logic dsi_seen;
  logic align_seen;

  // Decode one instruction word into its kind
  function automatic ecab_pkg::ecab_dec_t decode(input logic [31:0] w);
    ecab_pkg::ecab_dec_t d;
    d = ecab_pkg::ECAB_DEC_NONE;
    if (w[31:26] == ecab_pkg::OPC_PRIMARY && !w[0]) begin
      if (w[10:1] == ecab_pkg::XO_EXT_LOAD) begin
        d = ecab_pkg::ECAB_DEC_LOAD;
      end else if (w[10:1] == ecab_pkg::XO_EXT_STORE) begin
        d = ecab_pkg::ECAB_DEC_STORE;
      end else if (w[10:1] == ecab_pkg::XO_BARRIER && w[25:11] == 15'h0000) begin
        d = ecab_pkg::ECAB_DEC_BARRIER;
      end
    end
    return d;
  endfunction : decode

  // Effective address: base counts as zero when its field is zero
  function automatic logic [63:0] ea_form(input logic [4:0] ra, input logic [63:0] base,
                                          input logic [63:0] index);
    return ((ra == 5'h00) ? 64'h0 : base) + index;
  endfunction : ea_form

  // Ordering class of an ordinary access; a faulting dcbz is in neither
  function automatic logic [1:0] classify(input ecab_pkg::ecab_op_t o);
    logic st;
    logic c1;
    logic c2;
    st = o.store | o.dcbz;
    c1 = o.ci_guarded | (st & o.wt_req);
    c2 = st & o.cache_allowed & ~o.wt_req & o.coherent;
    return o.align_fault ? 2'h0 : {c1, c2};
  endfunction : classify

  // Combinational view of the op being offered
  logic op_acc;
  ecab_pkg::ecab_dec_t dec_now;
  logic is_instr;
  logic ext_acc;
  logic bar_acc;
  logic [63:0] ea_now;
  logic ext_en;
  logic mis_now;
  logic trap_now;
  logic [1:0] cls_now;
  logic fenced;
  logic issue_go;
  logic ack1;
  logic ack2;

  assign op_acc = op_valid_i && op_ready_o;
  assign dec_now = decode(op_i.instr);
  assign is_instr = op_i.kind == ecab_pkg::ECAB_OP_INSTR;
  assign ext_acc = op_acc && is_instr &&
                   (dec_now == ecab_pkg::ECAB_DEC_LOAD || dec_now == ecab_pkg::ECAB_DEC_STORE);
  assign bar_acc = op_acc && is_instr && dec_now == ecab_pkg::ECAB_DEC_BARRIER;
  assign ea_now = ea_form(op_i.instr[20:16], gpr_i.base_gpr, gpr_i.index_gpr);
  assign ext_en = ext_access_reg[ecab_pkg::EXT_EN_BIT];
  assign mis_now = ea_now[1:0] != 2'h0;
  assign trap_now = mis_now && ctrl_reg[ecab_pkg::CTRL_ALIGN_BIT];
  assign cls_now = classify(op_i);
  // Later accesses of a fenced class wait until earlier ones are acknowledged
  assign fenced = (hold_q.cls1 && fence1) || (hold_q.cls2 && fence2);
  assign issue_go = state == ecab_pkg::ECAB_ISSUE && !fenced && (!mem_valid_o || mem_ready_i);
  assign ack1 = mem_ack_i && mem_ack_data_i.cls1;
  assign ack2 = mem_ack_i && mem_ack_data_i.cls2;

  // Sequencer: accepts ops, translates, stages and waits for load data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ecab_pkg::ECAB_IDLE;
      op_ready_o <= 1'b0;
      hold_q <= '0;
      tgt_q <= 5'h00;
      st_q <= 1'b0;
      src_q <= 32'h0000_0000;
      rid_q <= '0;
      xl_req_o <= 1'b0;
      xl_ea_o <= 64'h0;
      xl_store_o <= 1'b0;
      gpr_wr_valid_o <= 1'b0;
      gpr_wr_tgt_o <= 5'h00;
      gpr_wr_data_o <= 64'h0;
      dsi_o <= 1'b0;
      align_o <= 1'b0;
      ill_o <= 1'b0;
      bcast_o <= 1'b0;
    end else begin
      // Pulses last one cycle
      gpr_wr_valid_o <= 1'b0;
      dsi_o <= 1'b0;
      align_o <= 1'b0;
      ill_o <= 1'b0;
      bcast_o <= 1'b0;
      unique case (state)
        ecab_pkg::ECAB_IDLE: begin
          op_ready_o <= 1'b1;
          if (op_acc && !is_instr) begin
            // Ordinary access: stage it for the ordering check
            hold_q.addr <= op_i.addr;
            hold_q.data <= op_i.data;
            hold_q.store <= op_i.store | op_i.dcbz;
            hold_q.bypass <= ~op_i.cache_allowed;
            hold_q.ext <= 1'b0;
            hold_q.rid <= '0;
            hold_q.cls1 <= cls_now[1];
            hold_q.cls2 <= cls_now[0];
            op_ready_o <= 1'b0;
            state <= ecab_pkg::ECAB_ISSUE;
          end else if (bar_acc) begin
            // Barrier retires at once; the fences do the waiting
            bcast_o <= 1'b1;
          end else if (ext_acc) begin
            tgt_q <= op_i.instr[25:21];
            st_q <= dec_now == ecab_pkg::ECAB_DEC_STORE;
            src_q <= gpr_i.source_gpr[31:0];
            rid_q <= ext_access_reg[ecab_pkg::RID_W-1:0];
            if (!ext_en) begin
              // Disabled access never reaches the device, even if misaligned
              dsi_o <= 1'b1;
            end else if (trap_now) begin
              align_o <= 1'b1;
            end else if (ctrl_reg[ecab_pkg::CTRL_DR_BIT]) begin
              // Translate as a one-byte access of the right direction
              xl_req_o <= 1'b1;
              xl_ea_o <= ea_now;
              xl_store_o <= dec_now == ecab_pkg::ECAB_DEC_STORE;
              op_ready_o <= 1'b0;
              state <= ecab_pkg::ECAB_XLATE;
            end else begin
              // Real mode: EA used untranslated, result is boundedly undefined
              hold_q.addr <= {ea_now[63:2], 2'h0};
              hold_q.data <= {32'h0000_0000, gpr_i.source_gpr[31:0]};
              hold_q.store <= dec_now == ecab_pkg::ECAB_DEC_STORE;
              hold_q.bypass <= 1'b1;
              hold_q.ext <= 1'b1;
              hold_q.rid <= ext_access_reg[ecab_pkg::RID_W-1:0];
              hold_q.cls1 <= 1'b1;
              hold_q.cls2 <= 1'b0;
              op_ready_o <= 1'b0;
              state <= ecab_pkg::ECAB_ISSUE;
            end
          end else if (op_acc) begin
            ill_o <= 1'b1;
          end
        end
        ecab_pkg::ECAB_XLATE: begin
          if (xl_ack_i) begin
            xl_req_o <= 1'b0;
            if (xl_fault_i) begin
              // Protection failure reported as a data storage fault
              dsi_o <= 1'b1;
              op_ready_o <= 1'b1;
              state <= ecab_pkg::ECAB_IDLE;
            end else begin
              // Misaligned low bits are dropped: the word is undefined anyway
              hold_q.addr <= {xl_paddr_i[63:2], 2'h0};
              hold_q.data <= {32'h0000_0000, src_q};
              hold_q.store <= st_q;
              hold_q.bypass <= 1'b1;
              hold_q.ext <= 1'b1;
              hold_q.rid <= rid_q;
              hold_q.cls1 <= 1'b1;
              hold_q.cls2 <= 1'b0;
              state <= ecab_pkg::ECAB_ISSUE;
            end
          end
        end
        ecab_pkg::ECAB_ISSUE: begin
          if (issue_go) begin
            if (hold_q.ext && !hold_q.store) begin
              state <= ecab_pkg::ECAB_LDWAIT;
            end else begin
              op_ready_o <= 1'b1;
              state <= ecab_pkg::ECAB_IDLE;
            end
          end
        end
        ecab_pkg::ECAB_LDWAIT: begin
          if (mem_ack_i && mem_ack_data_i.ext_load) begin
            gpr_wr_valid_o <= 1'b1;
            gpr_wr_tgt_o <= tgt_q;
            gpr_wr_data_o <= {32'h0000_0000, mem_ack_data_i.data};
            op_ready_o <= 1'b1;
            state <= ecab_pkg::ECAB_IDLE;
          end
        end
      endcase
    end
  end

  // Memory queue output register; one request in flight on the port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_valid_o <= 1'b0;
      mem_req_o <= '0;
    end else if (issue_go) begin
      // Single in-order port keeps guarded stores in program order
      mem_valid_o <= 1'b1;
      mem_req_o <= hold_q;
    end else if (mem_ready_i) begin
      mem_valid_o <= 1'b0;
    end
  end

  // Outstanding counters; saturation is not handled, size CNT_W for the queue depth
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt1 <= '0;
      cnt2 <= '0;
    end else begin
      cnt1 <= cnt1 + CNT_W'(issue_go && hold_q.cls1) - CNT_W'(ack1);
      cnt2 <= cnt2 + CNT_W'(issue_go && hold_q.cls2) - CNT_W'(ack2);
    end
  end

  // Barrier fences: raised by the barrier, dropped once the class drains
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fence1 <= 1'b0;
      fence2 <= 1'b0;
    end else begin
      if (bar_acc && cnt1 != '0) begin
        fence1 <= 1'b1;
      end else if (cnt1 == '0) begin
        fence1 <= 1'b0;
      end
      if (bar_acc && cnt2 != '0) begin
        fence2 <= 1'b1;
      end else if (cnt2 == '0) begin
        fence2 <= 1'b0;
      end
    end
  end

  // Wishbone: ack one cycle after the strobe, write on the ack edge
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_mux;
  logic [31:0] wmask;

  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_we_i && wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Read selection; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      ecab_pkg::REG_EXT_ACCESS: begin
        rd_mux[ecab_pkg::EXT_EN_BIT] = ext_access_reg[ecab_pkg::EXT_EN_BIT];
        rd_mux[ecab_pkg::RID_W-1:0] = ext_access_reg[ecab_pkg::RID_W-1:0];
      end
      ecab_pkg::REG_CTRL: begin
        rd_mux[ecab_pkg::CTRL_DR_BIT] = ctrl_reg[ecab_pkg::CTRL_DR_BIT];
        rd_mux[ecab_pkg::CTRL_ALIGN_BIT] = ctrl_reg[ecab_pkg::CTRL_ALIGN_BIT];
      end
      ecab_pkg::REG_STATUS: begin
        rd_mux[ecab_pkg::ST_STATE_LSB +: 2] = state;
        rd_mux[ecab_pkg::ST_FENCE1_BIT] = fence1;
        rd_mux[ecab_pkg::ST_FENCE2_BIT] = fence2;
        rd_mux[ecab_pkg::ST_DSI_BIT] = dsi_seen;
        rd_mux[ecab_pkg::ST_ALIGN_BIT] = align_seen;
        rd_mux[ecab_pkg::ST_CNT1_LSB +: 8] = 8'(cnt1);
        rd_mux[ecab_pkg::ST_CNT2_LSB +: 8] = 8'(cnt2);
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Bus handshake and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // Software registers; only defined bits are stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_access_reg <= ecab_pkg::EXT_ACCESS_RST;
      ctrl_reg <= ecab_pkg::CTRL_RST;
    end else if (wb_wr && wb_adr_i == ecab_pkg::REG_EXT_ACCESS) begin
      ext_access_reg <= (ext_access_reg & ~wmask) | (wb_dat_i & wmask &
                        ((32'h1 << ecab_pkg::EXT_EN_BIT) | 32'(2**ecab_pkg::RID_W - 1)));
    end else if (wb_wr && wb_adr_i == ecab_pkg::REG_CTRL) begin
      ctrl_reg <= (ctrl_reg & ~wmask) | (wb_dat_i & wmask & 32'h0000_0003);
    end
  end

  // Sticky fault flags, write one to clear; a new fault wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsi_seen <= 1'b0;
      align_seen <= 1'b0;
    end else begin
      if (dsi_o) begin
        dsi_seen <= 1'b1;
      end else if (wb_wr && wb_adr_i == ecab_pkg::REG_STATUS && wb_sel_i[1] &&
                   wb_dat_i[ecab_pkg::ST_DSI_BIT]) begin
        dsi_seen <= 1'b0;
      end
      if (align_o) begin
        align_seen <= 1'b1;
      end else if (wb_wr && wb_adr_i == ecab_pkg::REG_STATUS && wb_sel_i[1] &&
                   wb_dat_i[ecab_pkg::ST_ALIGN_BIT]) begin
        align_seen <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence load_acc_s;
    ext_acc && dec_now == ecab_pkg::ECAB_DEC_LOAD && ext_en && !trap_now;
  endsequence
  sequence store_acc_s;
    ext_acc && dec_now == ecab_pkg::ECAB_DEC_STORE && ext_en && !trap_now;
  endsequence
  sequence ld_done_s;
    state == ecab_pkg::ECAB_LDWAIT && mem_ack_i && mem_ack_data_i.ext_load;
  endsequence

  load_decode_a: assert property (load_acc_s |=> state != ecab_pkg::ECAB_IDLE && !st_q)
    else $error("ext load not started");
  store_decode_a: assert property (store_acc_s |=> state != ecab_pkg::ECAB_IDLE && st_q)
    else $error("ext store not started");
  ea_form_a: assert property ((load_acc_s or store_acc_s) ##0 ctrl_reg[ecab_pkg::CTRL_DR_BIT]
                              |=> xl_req_o && xl_ea_o == $past(ea_now))
    else $error("wrong effective address");
  high_clear_a: assert property (ld_done_s |=> gpr_wr_valid_o && gpr_wr_data_o ==
                                 {32'h0000_0000, $past(mem_ack_data_i.data)})
    else $error("load word not placed in low half");
  ext_bypass_a: assert property (issue_go && hold_q.ext |=> mem_valid_o && mem_req_o.bypass
                                 && mem_req_o.rid == rid_q)
    else $error("ext request not bypassing");
  // Checked at launch: a later op may reload src_q while the store still waits for ready
  store_word_a: assert property (issue_go && hold_q.ext && hold_q.store
                                 |=> mem_req_o.data == {32'h0000_0000, $past(src_q)})
    else $error("ext store data wrong");
  ext_disable_a: assert property (ext_acc && !ext_en |=> dsi_o && !xl_req_o
                                  && state == ecab_pkg::ECAB_IDLE)
    else $error("disabled ext access not faulted");
  align_trap_a: assert property (ext_acc && ext_en && trap_now |=> align_o && !dsi_o
                                 && state == ecab_pkg::ECAB_IDLE)
    else $error("misaligned ext access not trapped");
  xlate_dir_a: assert property (state == ecab_pkg::ECAB_XLATE |-> xl_store_o == st_q)
    else $error("translation direction wrong");
  class_cls_a: assert property (op_acc && !is_instr |=> hold_q.store == $past(op_i.store |
                                op_i.dcbz) && (!$past(op_i.align_fault) ||
                                (!hold_q.cls1 && !hold_q.cls2)))
    else $error("access classified wrongly");
  fence_one_a: assert property (bar_acc && cnt1 != '0 |=> fence1)
    else $error("class one fence not raised");
  fence_two_a: assert property (bar_acc && cnt2 != '0 |=> fence2)
    else $error("class two fence not raised");
  // Back-to-back barriers may keep the pulse high for a second cycle
  bar_done_a: assert property (bar_acc |=> op_ready_o && bcast_o
                               ##1 (!bcast_o || $past(bar_acc)))
    else $error("barrier did not retire with one pulse");

endmodule : ecab_unit

// >>> pkg/ecab_pkg.sv
// Constants, field layouts and carrier types for the external-control access and barrier unit
package ecab_pkg;

  // Instruction encoding
  localparam logic [5:0] OPC_PRIMARY = 6'h1f;
  localparam logic [9:0] XO_EXT_LOAD = 10'h136;
  localparam logic [9:0] XO_EXT_STORE = 10'h1b6;
  localparam logic [9:0] XO_BARRIER = 10'h356;

  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] REG_EXT_ACCESS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // ext_access_reg layout and reset value
  localparam int EXT_EN_BIT = 31;
  localparam int RID_W = 6;
  localparam logic [31:0] EXT_ACCESS_RST = 32'h0000_0000;

  // Control register layout and reset value
  localparam int CTRL_DR_BIT = 0;
  localparam int CTRL_ALIGN_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;

  // Status register layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FENCE1_BIT = 3;
  localparam int ST_FENCE2_BIT = 4;
  localparam int ST_DSI_BIT = 8;
  localparam int ST_ALIGN_BIT = 9;
  localparam int ST_CNT1_LSB = 16;
  localparam int ST_CNT2_LSB = 24;

  // Sequencer states, Gray coded along idle-xlate-issue-ldwait
  typedef enum logic [1:0] {
    ECAB_IDLE = 2'h0,
    ECAB_XLATE = 2'h1,
    ECAB_ISSUE = 2'h3,
    ECAB_LDWAIT = 2'h2
  } ecab_state_t;

  // Kind of work on the op port
  typedef enum logic {
    ECAB_OP_INSTR = 1'b0,
    ECAB_OP_ACCESS = 1'b1
  } ecab_kind_t;

  // Instruction decode result
  typedef enum logic [1:0] {
    ECAB_DEC_NONE = 2'h0,
    ECAB_DEC_LOAD = 2'h1,
    ECAB_DEC_STORE = 2'h2,
    ECAB_DEC_BARRIER = 2'h3
  } ecab_dec_t;

  // One op from the pipeline: an instruction or an ordinary access
  typedef struct packed {
    ecab_kind_t kind;
    logic [31:0] instr;
    logic [63:0] addr;
    logic [63:0] data;
    logic store;
    logic dcbz;
    logic ci_guarded;
    logic wt_req;
    logic coherent;
    logic cache_allowed;
    logic align_fault;
  } ecab_op_t;

  // Register operands read for the instruction
  typedef struct packed {
    logic [63:0] base_gpr;
    logic [63:0] index_gpr;
    logic [63:0] source_gpr;
  } ecab_gpr_t;

  // Request into the memory queue
  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic store;
    logic bypass;
    logic ext;
    logic [RID_W-1:0] rid;
    logic cls1;
    logic cls2;
  } ecab_mreq_t;

  // Completion from the memory subsystem
  typedef struct packed {
    logic cls1;
    logic cls2;
    logic ext_load;
    logic [31:0] data;
  } ecab_mack_t;

endpackage : ecab_pkg

// >>> verification/ecab_mem_model.sv
// Partner model: address translation and in-order memory queue with acks
`timescale 1ns/1ps
module ecab_mem_model (
  // Clock, reset and bench controls
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic fault_i,
  // Translation side
  input wire logic xl_req_i,
  input wire logic [63:0] xl_ea_i,
  output logic xl_ack_o,
  output logic [63:0] xl_paddr_o,
  output logic xl_fault_o,
  // Memory queue side
  input wire logic mem_valid_i,
  input wire ecab_pkg::ecab_mreq_t mem_req_i,
  output logic mem_ready_o,
  output logic mem_ack_o,
  output ecab_pkg::ecab_mack_t mem_ack_data_o
);
  ecab_pkg::ecab_mack_t pend[$]; // Accepted requests not yet completed
  logic [3:0] cyc; // Free-running stall pattern
  // Slow mode stalls on a pattern so both prompt and late answers occur
  always @(posedge clk_i) begin
    cyc <= rst_i ? 4'h0 : cyc + 4'h1;
    xl_ack_o <= !rst_i && xl_req_i && !xl_ack_o && (!slow_i || cyc[0]);
    xl_fault_o <= fault_i && xl_req_i;
    xl_paddr_o <= xl_req_i ? xl_ea_i : ~xl_paddr_o; // Identity map, garbage when idle
    mem_ready_o <= !rst_i && (!slow_i || cyc[1]);
    mem_ack_o <= 1'b0;
    mem_ack_data_o <= ~mem_ack_data_o; // Stale data never looks valid
    if (rst_i) pend.delete();
    else if (mem_valid_i && mem_ready_o) begin
      pend.push_back({mem_req_i.cls1, mem_req_i.cls2, !mem_req_i.store && mem_req_i.ext,
                      mem_req_i.addr[31:0] ^ 32'hc3a5_0000});
    end
    // Completions leave strictly in acceptance order
    if (!rst_i && pend.size() > 0 && cyc[2]) begin
      mem_ack_o <= 1'b1;
      mem_ack_data_o <= pend.pop_front();
    end
  end
endmodule : ecab_mem_model

// >>> verification/ecab_unit_tb.sv
// Self-checking bench for the external-control access and barrier unit
`timescale 1ns/1ps
module ecab_unit_tb;
  logic clk_i = 0, rst_i = 1, op_valid_i = 0, slow = 0, fault = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  ecab_pkg::ecab_op_t op_i = '0;
  ecab_pkg::ecab_gpr_t gpr_i = '0;
  ecab_pkg::ecab_mreq_t mem_req_o, last_req;
  ecab_pkg::ecab_mack_t mack;
  logic op_ready_o, gpr_wr_valid_o, dsi_o, align_o, ill_o, xl_req_o, xl_store_o, xl_ack_i;
  logic xl_fault_i, mem_valid_o, mem_ready_i, mem_ack_i, bcast_o, wb_ack_o;
  logic [4:0] gpr_wr_tgt_o, last_tgt;
  logic [63:0] gpr_wr_data_o, xl_ea_o, xl_paddr_i, last_wr, ea;
  logic [5:0] rid;
  logic [4:0] a;
  int errors = 0, n_tests = 0, seed = 32'h005e, n_acc = 0, n_wr = 0, n_dsi = 0, n_ill = 0;
  int n_bc = 0, c, i, n_al = 0, n_ack = 0, ack_at_acc = 0;
  always #25 clk_i = ~clk_i; // 20 MHz
  ecab_unit dut (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .gpr_i(gpr_i), .op_ready_o(op_ready_o), .gpr_wr_valid_o(gpr_wr_valid_o),
    .gpr_wr_tgt_o(gpr_wr_tgt_o), .gpr_wr_data_o(gpr_wr_data_o), .dsi_o(dsi_o),
    .align_o(align_o), .ill_o(ill_o), .xl_req_o(xl_req_o), .xl_ea_o(xl_ea_o),
    .xl_store_o(xl_store_o), .xl_ack_i(xl_ack_i), .xl_paddr_i(xl_paddr_i),
    .xl_fault_i(xl_fault_i), .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o),
    .mem_ready_i(mem_ready_i), .mem_ack_i(mem_ack_i), .mem_ack_data_i(mack),
    .bcast_o(bcast_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  ecab_mem_model far (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .fault_i(fault),
    .xl_req_i(xl_req_o), .xl_ea_i(xl_ea_o), .xl_ack_o(xl_ack_i), .xl_paddr_o(xl_paddr_i),
    .xl_fault_o(xl_fault_i), .mem_valid_i(mem_valid_o), .mem_req_i(mem_req_o),
    .mem_ready_o(mem_ready_i), .mem_ack_o(mem_ack_i), .mem_ack_data_o(mack));
  // Monitor: values read here are those sampled at the edge
  always @(posedge clk_i) begin
    if (mem_valid_o === 1'b1 && mem_ready_i) begin last_req = mem_req_o; n_acc++;
      ack_at_acc = n_ack; end
    if (gpr_wr_valid_o === 1'b1) begin last_wr = gpr_wr_data_o; last_tgt = gpr_wr_tgt_o;
      n_wr++; end
    n_dsi += (dsi_o === 1'b1); n_ill += (ill_o === 1'b1); n_bc += (bcast_o === 1'b1);
    n_al += (align_o === 1'b1); n_ack += (mem_ack_i === 1'b1);
  end
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin $display("BAD %s exp %h seen %h", nm, exp, seen); errors++; end
  endtask : check
  // Bounded wait for an event counter to reach a target
  task automatic wait_ev(ref int cnt, input int tgt);
    int k;
    for (k = 0; k < 300 && cnt < tgt; k++) @(posedge clk_i);
    check("event_count", cnt >= tgt, 1);
    if (cnt < tgt) end_sim;
  endtask : wait_ev
  // Classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= adr; wb_dat_i <= d;
    for (k = 0; k < 50; k++) begin @(posedge clk_i); if (wb_ack_o === 1'b1) break; end
    if (k == 50) begin errors++; end_sim; end
    q = wb_dat_o; wb_cyc_i <= 0; wb_stb_i <= 0;
  endtask : wb
  // Offer one instruction, held until the unit takes it
  task automatic do_op(input logic [9:0] xo, input logic [4:0] d, ra, input logic r);
    int k;
    @(posedge clk_i);
    // Barrier has all register fields zero; the others name index register 2
    op_valid_i <= 1;
    op_i.instr <= {ecab_pkg::OPC_PRIMARY, d, ra,
                   (xo == ecab_pkg::XO_BARRIER) ? 5'h0 : 5'h2, xo, r};
    for (k = 0; k < 100; k++) begin @(posedge clk_i); if (op_ready_o === 1'b1) break; end
    if (k == 100) begin errors++; end_sim; end
    op_valid_i <= 0;
  endtask : do_op
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    wb(0, ecab_pkg::REG_EXT_ACCESS, 0); check("ext_access_rst", q, 0);
    wb(0, ecab_pkg::REG_CTRL, 0); check("ctrl_rst", q, ecab_pkg::CTRL_RST);
    wb(1, 4'hc, 32'hffff_ffff); wb(0, 4'hc, 0); check("unmapped", q, 0);
    c = n_dsi; do_op(ecab_pkg::XO_EXT_LOAD, 5'h3, 5'h1, 0); wait_ev(n_dsi, c + 1);
    check("no_access", n_acc, 0);
    wb(0, ecab_pkg::REG_STATUS, 0); check("dsi_sticky", q, 32'h0000_0100);
    wb(1, ecab_pkg::REG_STATUS, 32'h0000_0100); wb(0, ecab_pkg::REG_STATUS, 0);
    check("dsi_clear", q, 0);
    rid = 6'($random(seed));
    wb(1, ecab_pkg::REG_EXT_ACCESS, {1'b1, 25'h0, rid});
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 5'h0 : 5'(i + 4);
      slow <= i[0];
      gpr_i <= {{$random(seed), $random(seed)} & ~64'h3, {$random(seed), $random(seed)} & ~64'h3,
                {$random(seed), $random(seed)}};
      c = n_wr; do_op(ecab_pkg::XO_EXT_LOAD, 5'(i + 9), a, 0); wait_ev(n_wr, c + 1);
      ea = (a == 0 ? 64'h0 : gpr_i.base_gpr) + gpr_i.index_gpr;
      check("ld_addr", last_req.addr, ea);
      check("ld_kind", {last_req.store, last_req.bypass, last_req.ext, last_req.cls1}, 4'h7);
      check("ld_rid", last_req.rid, rid);
      check("ld_data", last_wr, {32'h0, ea[31:0] ^ 32'hc3a5_0000});
      check("ld_tgt", last_tgt, i + 9);
      c = n_acc; do_op(ecab_pkg::XO_EXT_STORE, 5'h4, a, 0); wait_ev(n_acc, c + 1);
      check("st_addr", last_req.addr, ea);
      check("st_kind", {last_req.store, last_req.bypass, last_req.ext, last_req.cls1}, 4'hf);
      check("st_rid", last_req.rid, rid);
      check("st_data", last_req.data[31:0], gpr_i.source_gpr[31:0]);
    end
    // Guarded store, coherent store, barrier, guarded load: the load waits for the first ack
    op_i.kind <= ecab_pkg::ECAB_OP_ACCESS; op_i.store <= 1; op_i.ci_guarded <= 1;
    op_i.addr <= {$random(seed), $random(seed)}; c = n_acc; do_op(0, 0, 0, 0);
    op_i.ci_guarded <= 0; op_i.cache_allowed <= 1; op_i.coherent <= 1; do_op(0, 0, 0, 0);
    op_i.kind <= ecab_pkg::ECAB_OP_INSTR; do_op(ecab_pkg::XO_BARRIER, 0, 0, 0);
    op_i.kind <= ecab_pkg::ECAB_OP_ACCESS; op_i.store <= 0; op_i.ci_guarded <= 1;
    op_i.cache_allowed <= 0; op_i.coherent <= 0; do_op(0, 0, 0, 0); wait_ev(n_acc, c + 3);
    check("fence_order", ack_at_acc >= c + 1, 1);
    check("acc_kind", {last_req.store, last_req.cls1, last_req.cls2}, 3'h2);
    op_i.kind <= ecab_pkg::ECAB_OP_INSTR;
    c = n_bc; do_op(ecab_pkg::XO_BARRIER, 0, 0, 0); wait_ev(n_bc, c + 1);
    c = n_ill; do_op(ecab_pkg::XO_BARRIER, 0, 0, 1); wait_ev(n_ill, c + 1);
    do_op(ecab_pkg::XO_EXT_LOAD, 5'h1, 5'h1, 1); wait_ev(n_ill, c + 2);
    // Real mode: the address goes out untranslated
    wb(1, ecab_pkg::REG_CTRL, 32'h2); c = n_wr;
    do_op(ecab_pkg::XO_EXT_LOAD, 5'h7, 5'h5, 0); wait_ev(n_wr, c + 1);
    check("real_addr", last_req.addr, ea);
    check("real_data", last_wr, {32'h0, ea[31:0] ^ 32'hc3a5_0000});
    gpr_i.index_gpr <= gpr_i.index_gpr | 64'h1; c = n_acc;
    do_op(ecab_pkg::XO_EXT_LOAD, 5'h7, 5'h5, 0); wait_ev(n_al, 1);
    check("mis_no_acc", n_acc, c);
    wb(0, ecab_pkg::REG_STATUS, 0); check("align_sticky", q[9:8], 2'h2);
    gpr_i.index_gpr <= gpr_i.index_gpr & ~64'h3; wb(1, ecab_pkg::REG_CTRL, 32'h3);
    fault <= 1; c = n_dsi;
    do_op(ecab_pkg::XO_EXT_LOAD, 5'h1, 5'h1, 0); wait_ev(n_dsi, c + 1);
    repeat (20) @(posedge clk_i);
    end_sim;
  end
endmodule : ecab_unit_tb
